// *** design/mem_decode_pkg.sv ***
// Shared constants and types for the memory space decoder
package mem_decode_pkg;

  localparam int         PROG_SPACE_BYTES = 65536;
  localparam int         PROG_MAX_BYTES   = 8192;
  localparam logic [15:0] PROG_TOP        = 16'h1FFF;
  localparam logic [15:0] FACTORY_BASE    = 16'h1E00;
  localparam int         RAM_MAX_BYTES    = 256;
  localparam int         RAM_SMALL_BYTES  = 128;
  localparam logic [7:0] LOWER_TOP        = 8'h7F;
  localparam logic [7:0] STACK_PTR_ADDR   = 8'h81;
  localparam logic [7:0] STATUS_ADDR      = 8'hD0;
  localparam logic [7:0] STACK_PTR_RESET  = 8'h07;
  localparam logic [7:0] STATUS_RESET     = 8'h00;
  localparam logic [7:0] BIT_AREA_BASE    = 8'h20;
  localparam logic [7:0] BLANK_BYTE       = 8'hFF;
  localparam int         BANK_LO_BIT      = 3;
  localparam int         BANK_HI_BIT      = 4;

  typedef enum logic [2:0] {
    S_IDLE,
    S_PTR,
    S_TGT,
    S_RAMRD,
    S_SPRD,
    S_CODE
  } state_t;

  typedef enum logic [2:0] {
    R_RAM,
    R_STACK,
    R_STATUS,
    R_SPECIAL,
    R_NONE
  } region_t;

endpackage

// *** design/data_ram.sv ***
// Internal data RAM with registered read data
`timescale 1ns/100ps
module data_ram #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output      logic [7:0]    rdata
);

  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule // data_ram

// *** design/prog_array.sv ***
// One-time programmable code array, write port for the programmer only
`timescale 1ns/100ps
module prog_array #(
  parameter int BYTES = 8192,
  parameter int AW    = 13
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddr,
  output      logic [7:0]    rdata
);

  logic [7:0] mem [BYTES];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule // prog_array

// *** design/mem_decode.sv ***
// Program and data memory space decoder with stack pointer and status word
`timescale 1ns/100ps
module mem_decode #(
  parameter int PROG_BYTES = mem_decode_pkg::PROG_MAX_BYTES,
  parameter int RAM_BYTES  = mem_decode_pkg::RAM_MAX_BYTES
) (
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        REQ,
  input  wire logic        CODE,
  input  wire logic        TABLE_RD,
  input  wire logic        WR,
  input  wire logic        IND,
  input  wire logic        BITOP,
  input  wire logic        PUSH,
  input  wire logic        POP,
  input  wire logic        PTR,
  input  wire logic [15:0] ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WBIT,
  input  wire logic        PROG_WE,
  input  wire logic [15:0] PROG_ADDR,
  input  wire logic [7:0]  PROG_DATA,
  input  wire logic [7:0]  SPECIAL_RDATA,
  output      logic        ACK,
  output      logic [7:0]  RDATA,
  output      logic        RBIT,
  output      logic        ERR,
  output      logic        SPECIAL_REQ,
  output      logic        SPECIAL_WR,
  output      logic [7:0]  SPECIAL_ADDR,
  output      logic [7:0]  SPECIAL_WDATA,
  output      logic [7:0]  STACK_TOP_POINTER,
  output      logic [7:0]  PROGRAM_STATUS_WORD
);

  localparam int ROM_AW = $clog2(PROG_BYTES);
  localparam int RAM_AW = $clog2(RAM_BYTES);

  mem_decode_pkg::state_t  state;
  mem_decode_pkg::state_t  next_state;
  mem_decode_pkg::region_t reg_now;

  logic        c_table;
  logic        c_wr;
  logic        c_ind;
  logic        c_bit;
  logic        c_push;
  logic        c_pop;
  logic        c_wbit;
  logic [7:0]  c_wdata;
  logic [15:0] c_addr;
  logic [7:0]  tgt;
  logic [2:0]  bpos;
  logic        fin;
  logic [7:0]  ans_byte;
  logic [7:0]  code_byte;
  logic        ram_we;
  logic [7:0]  ram_addr;
  logic [7:0]  ram_wdata;
  logic [7:0]  ram_rdata;
  logic        rom_we;
  logic [7:0]  rom_rdata;

  function automatic mem_decode_pkg::region_t region_of(logic [7:0] a, logic ind);
    if (a <= mem_decode_pkg::LOWER_TOP)
      return mem_decode_pkg::R_RAM;
    else if (ind)
      return (RAM_BYTES > mem_decode_pkg::RAM_SMALL_BYTES) ?
             mem_decode_pkg::R_RAM : mem_decode_pkg::R_NONE;
    else if (a == mem_decode_pkg::STACK_PTR_ADDR)
      return mem_decode_pkg::R_STACK;
    else if (a == mem_decode_pkg::STATUS_ADDR)
      return mem_decode_pkg::R_STATUS;
    else
      return mem_decode_pkg::R_SPECIAL;
  endfunction

  function automatic logic [7:0] bit_set(logic [7:0] b, logic [2:0] pos, logic v);
    logic [7:0] r;
    r      = b;
    r[pos] = v;
    return r;
  endfunction

  // Stored array, programmer port refuses the factory region
  assign rom_we = PROG_WE && (32'(PROG_ADDR) < PROG_BYTES)
                  && (PROG_ADDR < mem_decode_pkg::FACTORY_BASE);

  prog_array #(
    .BYTES (PROG_BYTES),
    .AW    (ROM_AW)
  ) u_prog (
    .clk   (CLK),
    .we    (rom_we),
    .waddr (PROG_ADDR[ROM_AW-1:0]),
    .wdata (PROG_DATA),
    .raddr (ADDR[ROM_AW-1:0]),
    .rdata (rom_rdata)
  );

  data_ram #(
    .DEPTH (RAM_BYTES),
    .AW    (RAM_AW)
  ) u_ram (
    .clk   (CLK),
    .we    (ram_we),
    .addr  (ram_addr[RAM_AW-1:0]),
    .wdata (ram_wdata),
    .rdata (ram_rdata)
  );

  assign reg_now = region_of(tgt, c_ind);

  always_comb
  begin
    // Pointer fetch reads work_reg_zero/one of the active bank
    if (state == mem_decode_pkg::S_IDLE)
      ram_addr = {3'h0, PROGRAM_STATUS_WORD[mem_decode_pkg::BANK_HI_BIT:
                  mem_decode_pkg::BANK_LO_BIT], 2'h0, PTR};
    else
      ram_addr = tgt;
    ram_we = ((state == mem_decode_pkg::S_TGT) && (reg_now == mem_decode_pkg::R_RAM)
              && c_wr && !c_bit)
             || ((state == mem_decode_pkg::S_RAMRD) && c_wr && c_bit);
    // Bit writes are read-modify-write of the holding byte
    ram_wdata = c_bit ? bit_set(ram_rdata, bpos, c_wbit) : c_wdata;
  end

  always_comb
  begin
    next_state = state;
    case (state)
      mem_decode_pkg::S_IDLE:
        if (REQ)
        begin
          if (CODE)
            next_state = mem_decode_pkg::S_CODE;
          else if (IND && !BITOP && !PUSH && !POP)
            next_state = mem_decode_pkg::S_PTR;
          else
            next_state = mem_decode_pkg::S_TGT;
        end
      mem_decode_pkg::S_PTR:
        next_state = mem_decode_pkg::S_TGT;
      mem_decode_pkg::S_TGT:
        case (reg_now)
          mem_decode_pkg::R_RAM:
            next_state = (c_wr && !c_bit) ? mem_decode_pkg::S_IDLE : mem_decode_pkg::S_RAMRD;
          mem_decode_pkg::R_SPECIAL:
            next_state = (c_wr && !c_bit) ? mem_decode_pkg::S_IDLE : mem_decode_pkg::S_SPRD;
          default:
            next_state = mem_decode_pkg::S_IDLE;
        endcase
      default:
        next_state = mem_decode_pkg::S_IDLE;
    endcase
  end

  assign fin = ((state == mem_decode_pkg::S_TGT) && (next_state == mem_decode_pkg::S_IDLE))
               || (state == mem_decode_pkg::S_RAMRD) || (state == mem_decode_pkg::S_SPRD)
               || (state == mem_decode_pkg::S_CODE);

  always_comb
  begin
    // Table reads of the factory block and fetches past the array read blank
    if ((32'(c_addr) >= PROG_BYTES)
        || (c_table && (c_addr >= mem_decode_pkg::FACTORY_BASE)
            && (c_addr <= mem_decode_pkg::PROG_TOP)))
      code_byte = mem_decode_pkg::BLANK_BYTE;
    else
      code_byte = rom_rdata;
    case (state)
      mem_decode_pkg::S_CODE:  ans_byte = code_byte;
      mem_decode_pkg::S_RAMRD: ans_byte = ram_rdata;
      mem_decode_pkg::S_SPRD:  ans_byte = SPECIAL_RDATA;
      default:
        case (reg_now)
          mem_decode_pkg::R_STACK:  ans_byte = STACK_TOP_POINTER;
          mem_decode_pkg::R_STATUS: ans_byte = PROGRAM_STATUS_WORD;
          default:                  ans_byte = mem_decode_pkg::BLANK_BYTE;
        endcase
    endcase
  end

  // Sequencer and command latch
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      state   <= mem_decode_pkg::S_IDLE;
      c_table <= 1'b0;
      c_wr    <= 1'b0;
      c_ind   <= 1'b0;
      c_bit   <= 1'b0;
      c_push  <= 1'b0;
      c_pop   <= 1'b0;
      c_wbit  <= 1'b0;
      c_wdata <= 8'h00;
      c_addr  <= 16'h0000;
      tgt     <= 8'h00;
      bpos    <= 3'h0;
    end
    else
    begin
      state <= next_state;
      if ((state == mem_decode_pkg::S_IDLE) && REQ)
      begin
        c_table <= TABLE_RD;
        c_wr    <= WR || PUSH;
        c_ind   <= (IND && !BITOP) || PUSH || POP;
        c_bit   <= BITOP && !PUSH && !POP;
        c_push  <= PUSH;
        c_pop   <= POP;
        c_wbit  <= WBIT;
        c_wdata <= WDATA;
        c_addr  <= ADDR;
        bpos    <= ADDR[2:0];
        if (PUSH)
          tgt <= STACK_TOP_POINTER + 8'h01;
        else if (POP)
          tgt <= STACK_TOP_POINTER;
        else if (BITOP && ADDR[7])
          tgt <= {ADDR[7:3], 3'h0};
        else if (BITOP)
          tgt <= mem_decode_pkg::BIT_AREA_BASE + {4'h0, ADDR[6:3]};
        else
          tgt <= ADDR[7:0];
      end
      else if (state == mem_decode_pkg::S_PTR)
        tgt <= ram_rdata;
    end
  end

  // Stack pointer and status word
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      STACK_TOP_POINTER   <= mem_decode_pkg::STACK_PTR_RESET;
      PROGRAM_STATUS_WORD <= mem_decode_pkg::STATUS_RESET;
    end
    else if (state == mem_decode_pkg::S_TGT)
    begin
      if (c_push && (reg_now == mem_decode_pkg::R_RAM))
        STACK_TOP_POINTER <= tgt;
      else if (c_wr && !c_bit && (reg_now == mem_decode_pkg::R_STACK))
        STACK_TOP_POINTER <= c_wdata;
      if (c_wr && (reg_now == mem_decode_pkg::R_STATUS))
        PROGRAM_STATUS_WORD <= c_bit ? bit_set(PROGRAM_STATUS_WORD, bpos, c_wbit) : c_wdata;
    end
    else if ((state == mem_decode_pkg::S_RAMRD) && c_pop)
      STACK_TOP_POINTER <= STACK_TOP_POINTER - 8'h01;
  end

  // Answer to the core
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      ACK   <= 1'b0;
      RDATA <= 8'h00;
      RBIT  <= 1'b0;
      ERR   <= 1'b0;
    end
    else
    begin
      ACK <= fin;
      if (fin)
      begin
        RDATA <= ans_byte;
        RBIT  <= ans_byte[bpos];
        // Code writes are dropped; firmware cannot alter the array
        ERR   <= ((state == mem_decode_pkg::S_CODE) && c_wr)
                 || ((state == mem_decode_pkg::S_TGT) && (reg_now == mem_decode_pkg::R_NONE));
      end
    end
  end

  // Peripheral register port; unoccupied addresses are passed through unchecked
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      SPECIAL_REQ   <= 1'b0;
      SPECIAL_WR    <= 1'b0;
      SPECIAL_ADDR  <= 8'h00;
      SPECIAL_WDATA <= 8'h00;
    end
    else
    begin
      SPECIAL_REQ <= 1'b0;
      SPECIAL_WR  <= 1'b0;
      if ((state == mem_decode_pkg::S_TGT) && (reg_now == mem_decode_pkg::R_SPECIAL))
      begin
        SPECIAL_REQ   <= 1'b1;
        SPECIAL_WR    <= c_wr && !c_bit;
        SPECIAL_ADDR  <= tgt;
        SPECIAL_WDATA <= c_wdata;
      end
      else if ((state == mem_decode_pkg::S_SPRD) && c_wr && c_bit)
      begin
        SPECIAL_REQ   <= 1'b1;
        SPECIAL_WR    <= 1'b1;
        SPECIAL_WDATA <= bit_set(SPECIAL_RDATA, bpos, c_wbit);
      end
    end
  end

  a_stack_reset_value:
    assert property (@(posedge CLK) $rose(RSTN) |-> STACK_TOP_POINTER == 8'h07)
    else $error("stack pointer not 0x07 after reset");

  a_push_increments:
    assert property (@(posedge CLK) disable iff (!RSTN)
      (state == mem_decode_pkg::S_IDLE && REQ && PUSH && !CODE)
      |-> ##1 (ram_we && ram_addr == $past(STACK_TOP_POINTER) + 8'h01)
          ##1 STACK_TOP_POINTER == $past(STACK_TOP_POINTER, 2) + 8'h01)
    else $error("push did not write above pointer and increment");

  a_bank_pointer_addr:
    assert property (@(posedge CLK) disable iff (!RSTN)
      (state == mem_decode_pkg::S_IDLE && REQ && IND && !BITOP && !CODE && !PUSH && !POP)
      |-> ram_addr == {3'h0, PROGRAM_STATUS_WORD[4:3], 2'h0, PTR})
    else $error("indirect pointer read from wrong bank register");

  a_bit_area_map:
    assert property (@(posedge CLK) disable iff (!RSTN)
      (state == mem_decode_pkg::S_IDLE && REQ && BITOP && !CODE && !PUSH && !POP && !ADDR[7])
      |=> tgt == 8'h20 + {4'h0, $past(ADDR[6:3])} && bpos == $past(ADDR[2:0]))
    else $error("bit address mapped to wrong byte");

  a_direct_high_special:
    assert property (@(posedge CLK) disable iff (!RSTN)
      (state == mem_decode_pkg::S_TGT && !c_ind && tgt[7] && tgt != 8'h81 && tgt != 8'hD0)
      |-> !ram_we ##1 (SPECIAL_REQ && SPECIAL_ADDR == $past(tgt)))
    else $error("direct high access not sent to special space");

  a_indirect_high_ram:
    assert property (@(posedge CLK) disable iff (!RSTN)
      (state == mem_decode_pkg::S_TGT && c_ind && tgt[7]) |=> !SPECIAL_REQ)
    else $error("indirect high access reached special space");

  a_special_bit_align:
    assert property (@(posedge CLK) disable iff (!RSTN)
      (SPECIAL_REQ && c_bit) |-> SPECIAL_ADDR[2:0] == 3'h0)
    else $error("bit access to non bit-addressable register");

  a_code_answer_time:
    assert property (@(posedge CLK) disable iff (!RSTN)
      (state == mem_decode_pkg::S_IDLE && REQ && CODE) |-> ##1 !ACK ##1 ACK ##1 !ACK)
    else $error("code access answer not two cycles after request");

  a_factory_protect:
    assert property (@(posedge CLK) disable iff (!RSTN)
      rom_we |-> PROG_WE && PROG_ADDR < 16'h1E00)
    else $error("write reached reserved or firmware path");

  a_small_upper_error:
    assert property (@(posedge CLK) disable iff (!RSTN)
      (state == mem_decode_pkg::S_TGT && c_ind && tgt[7] && RAM_BYTES == 128)
      |=> ACK && ERR)
    else $error("upper RAM access on small variant not flagged");

endmodule // mem_decode

// *** test/special_regs_model.sv ***
// Behavioural special register space on the far side of the decoder
`timescale 1ns/100ps
module special_regs_model (
  input  wire logic       clk,
  input  wire logic       req,
  input  wire logic       wr,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  output      logic [7:0] rdata
);
  logic [7:0] regs [256];
  logic [7:0] last;

  // Known per-address contents so reads can be predicted
  initial
  begin
    last = 8'h00;
    for (int i = 0; i < 256; i++)
      regs[i] = 8'(i) ^ 8'h5A;
  end

  always @(posedge clk)
  begin
    if (req && wr)
      regs[addr] <= wdata;
    if (req && !wr)
      last <= regs[addr];
  end

  // Idle bus shows the inverse of the last value, never a stale copy
  assign rdata = (req && !wr) ? regs[addr] : ~last;
endmodule // special_regs_model

// *** test/mcu_memory_space_decode_tb_top.sv ***
// Self-checking bench for the memory space decoder
`timescale 1ns/100ps
module mcu_memory_space_decode_tb_top;
  localparam logic [7:0] F_CODE = 8'h80, F_TBL = 8'h40, F_WR = 8'h20, F_IND = 8'h10,
                         F_BIT = 8'h08, F_PUSH = 8'h04, F_POP = 8'h02, F_PTR = 8'h01;
  logic        CLK, RSTN, REQ, CODE, TABLE_RD, WR, IND, BITOP, PUSH, POP, PTR, WBIT;
  logic        PROG_WE, ACK, RBIT, ERR, SPECIAL_REQ, SPECIAL_WR;
  logic [15:0] ADDR, PROG_ADDR;
  logic [7:0]  WDATA, PROG_DATA, SPECIAL_RDATA, RDATA, SPECIAL_ADDR, SPECIAL_WDATA;
  logic [7:0]  STACK_TOP_POINTER, PROGRAM_STATUS_WORD;
  int          n_fail;
  int          compares;
  logic        small_err;
  logic [7:0]  small_rdata;

  mem_decode #(.PROG_BYTES(4096), .RAM_BYTES(256)) dut_u (
    .CLK(CLK), .RSTN(RSTN), .REQ(REQ), .CODE(CODE), .TABLE_RD(TABLE_RD), .WR(WR),
    .IND(IND), .BITOP(BITOP), .PUSH(PUSH), .POP(POP), .PTR(PTR), .ADDR(ADDR),
    .WDATA(WDATA), .WBIT(WBIT), .PROG_WE(PROG_WE), .PROG_ADDR(PROG_ADDR),
    .PROG_DATA(PROG_DATA), .SPECIAL_RDATA(SPECIAL_RDATA), .ACK(ACK), .RDATA(RDATA),
    .RBIT(RBIT), .ERR(ERR), .SPECIAL_REQ(SPECIAL_REQ), .SPECIAL_WR(SPECIAL_WR),
    .SPECIAL_ADDR(SPECIAL_ADDR), .SPECIAL_WDATA(SPECIAL_WDATA),
    .STACK_TOP_POINTER(STACK_TOP_POINTER), .PROGRAM_STATUS_WORD(PROGRAM_STATUS_WORD));

  special_regs_model spec_u (.clk(CLK), .req(SPECIAL_REQ), .wr(SPECIAL_WR),
    .addr(SPECIAL_ADDR), .wdata(SPECIAL_WDATA), .rdata(SPECIAL_RDATA));

  // Largest code array with small RAM, in lockstep; never slower than dut_u
  mem_decode #(.PROG_BYTES(8192), .RAM_BYTES(128)) dut_small_u (
    .CLK(CLK), .RSTN(RSTN), .REQ(REQ), .CODE(CODE), .TABLE_RD(TABLE_RD), .WR(WR),
    .IND(IND), .BITOP(BITOP), .PUSH(PUSH), .POP(POP), .PTR(PTR), .ADDR(ADDR),
    .WDATA(WDATA), .WBIT(WBIT), .PROG_WE(PROG_WE), .PROG_ADDR(PROG_ADDR),
    .PROG_DATA(PROG_DATA), .SPECIAL_RDATA(SPECIAL_RDATA), .ACK(), .RDATA(small_rdata),
    .RBIT(), .ERR(small_err), .SPECIAL_REQ(), .SPECIAL_WR(), .SPECIAL_ADDR(),
    .SPECIAL_WDATA(), .STACK_TOP_POINTER(), .PROGRAM_STATUS_WORD());

  initial
    CLK = 1'b0;
  always #50 CLK = ~CLK;

  task automatic print_verdict;
    if (n_fail == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One request, then a bounded wait for its answer
  task automatic acc(input logic [7:0] f, input logic [15:0] a, input logic [7:0] d,
                     input logic wb);
    int n;
    {CODE, TABLE_RD, WR, IND, BITOP, PUSH, POP, PTR} = f;
    ADDR = a;
    WDATA = d;
    WBIT = wb;
    REQ = 1'b1;
    @(posedge CLK);
    #1 REQ = 1'b0;
    n = 0;
    while (ACK !== 1'b1 && n < 20)
    begin
      @(posedge CLK);
      #1;
      n++;
    end
    chk1(ACK, 1'b1);
  endtask

  task automatic rd(input logic [7:0] f, input logic [15:0] a, input logic [7:0] exp);
    acc(f, a, 8'h00, 1'b0);
    chk8(RDATA, exp);
  endtask

  task automatic prog(input logic [15:0] a, input logic [7:0] d);
    PROG_ADDR = a;
    PROG_DATA = d;
    PROG_WE = 1'b1;
    @(posedge CLK);
    #1 PROG_WE = 1'b0;
    // Let an edge pass so a following write never re-raises in this step
    @(posedge CLK);
    #1;
  endtask

  task automatic t_reset;
    RSTN = 1'b0;
    repeat (2) @(posedge CLK);
    #1 RSTN = 1'b1;
    chk8(STACK_TOP_POINTER, 8'h07);
    chk8(PROGRAM_STATUS_WORD, 8'h00);
  endtask

  task automatic t_stack;
    acc(F_PUSH, 16'h0000, 8'hA5, 1'b0);
    chk8(STACK_TOP_POINTER, 8'h08);
    rd(8'h00, 16'h0008, 8'hA5);
    acc(F_PUSH, 16'h0000, 8'h3C, 1'b0);
    rd(8'h00, 16'h0009, 8'h3C);
    rd(F_POP, 16'h0000, 8'h3C);
    rd(8'h00, 16'h0081, 8'h08);
  endtask

  // Same indirect request lands in a different bank per select value
  task automatic t_banks;
    for (int b = 0; b < 4; b++)
    begin
      acc(F_WR, 16'h00D0, 8'(b << 3), 1'b0);
      chk8(PROGRAM_STATUS_WORD, 8'(b << 3));
      acc(F_WR, 16'(8 * b), 8'(8'h40 + b), 1'b0);
      acc(F_WR, 16'(16'h0040 + b), 8'(8'hC0 + b), 1'b0);
      rd(F_IND, 16'h0000, 8'(8'hC0 + b));
    end
    acc(F_WR, 16'h00D0, 8'h00, 1'b0);
  endtask

  // Pointer reaches upper RAM at 0xA8, direct address reaches the special register at 0xA8
  task automatic t_upper;
    acc(F_WR, 16'h0001, 8'hA8, 1'b0);
    acc(F_WR | F_IND | F_PTR, 16'h0000, 8'h3C, 1'b0);
    chk1(small_err, 1'b1);
    rd(F_IND | F_PTR, 16'h0000, 8'h3C);
    chk8(small_rdata, 8'hFF);
    rd(8'h00, 16'h00A8, 8'hF2);
    chk8(SPECIAL_ADDR, 8'hA8);
  endtask

  task automatic t_bits;
    acc(F_WR, 16'h0022, 8'h00, 1'b0);
    acc(F_WR | F_BIT, 16'h0013, 8'h00, 1'b1);
    rd(8'h00, 16'h0022, 8'h08);
    acc(F_BIT, 16'h0013, 8'h00, 1'b0);
    chk1(RBIT, 1'b1);
    acc(F_WR | F_BIT, 16'h0082, 8'h00, 1'b1);
    chk8(SPECIAL_WDATA, 8'hDE);
    rd(8'h00, 16'h0080, 8'hDE);
  endtask

  task automatic t_code;
    prog(16'h0030, 8'h9E);
    prog(16'h0FFF, 8'h5B);
    prog(16'h1DFF, 8'h6D);
    acc(F_WR, 16'h0030, 8'h11, 1'b0);
    rd(F_CODE, 16'h0030, 8'h9E);
    chk1(ERR, 1'b0);
    rd(8'h00, 16'h0030, 8'h11);
    rd(F_CODE | F_TBL, 16'h0FFF, 8'h5B);
    rd(F_CODE, 16'h1000, 8'hFF);
    rd(F_CODE, 16'h1DFF, 8'hFF);
    chk8(small_rdata, 8'h6D);
    rd(F_CODE | F_TBL, 16'h1E00, 8'hFF);
    chk8(small_rdata, 8'hFF);
    rd(F_CODE, 16'hFFFF, 8'hFF);
    acc(F_CODE | F_WR, 16'h0030, 8'h00, 1'b0);
    chk1(ERR, 1'b1);
    rd(F_CODE, 16'h0030, 8'h9E);
  endtask

  initial
  begin
    n_fail = 0;
    compares = 0;
    {REQ, CODE, TABLE_RD, WR, IND, BITOP, PUSH, POP, PTR, WBIT, PROG_WE} = '0;
    ADDR = 16'h0000;
    PROG_ADDR = 16'h0000;
    WDATA = 8'h00;
    PROG_DATA = 8'h00;
    t_reset();
    t_stack();
    t_reset();
    t_banks();
    t_upper();
    t_bits();
    t_code();
    print_verdict();
  end

  // Run needs about 120 cycles; allow ample margin
  initial
  begin
    #200000;
    n_fail++;
    print_verdict();
  end
endmodule // mcu_memory_space_decode_tb_top
